// ==== hw/ocp_top.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "ocp_cfg.svh"

// Overview of operation
// - Idle-halt bit freezes channel during CPU idle
// - Fault status set by hardware, cleared by a control register write unless a fault is live in that cycle
// - Timebase select picks second or first timer
// - Mode 111 runs PWM and watches fault
// - Mode 110 runs PWM, fault ignored
// - Mode 101 starts low, continuous pulses
// - Mode 100 starts low, exactly one pulse
// - Mode 011 toggles pin on each match
// - Mode 010 starts high, match forces low
// - Mode 001 starts low, match forces high
// - Mode 000 disables compare activity
// - Shared fault pin serves channels one, two
// - Channel replicable, index one through eight
// - Duty copied from secondary at period match
// - Duty zero low, above period high
// - Period N gives N plus one counts
// - Primary match rises, secondary falls, sets flag
module ocp_top #(
  parameter int unsigned CHAN_ID = 1
) (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output var logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output var logic s_axi_wready,
  output var logic [1:0] s_axi_bresp,
  output var logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output var logic s_axi_arready,
  output var logic [31:0] s_axi_rdata,
  output var logic [1:0] s_axi_rresp,
  output var logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic cpu_idle,
  input wire logic fault_input_a,
  output var logic compare_output_pin,
  output var logic irq
);

  // Control fields
  logic idle_halt_select;
  logic pwm_fault_status;
  logic timebase_select;
  ocp_pkg::ocp_mode_t compare_mode_field;
  // Compare values; primary doubles as duty in PWM
  logic [15:0] primary_compare_value;
  logic [15:0] secondary_compare_value;
  // Timebase periods and run enables
  logic [15:0] first_period;
  logic [15:0] second_period;
  logic run_first;
  logic run_second;
  // Interrupt status and mask
  logic [1:0] irq_status;
  logic [1:0] irq_mask;
  // One-shot still allowed to fire
  logic armed;
  // Captured write address, data and strobes
  logic [7:0] wa;
  logic [31:0] wd;
  logic [3:0] ws;
  logic aw_full;
  logic w_full;
  // Timebase outputs
  logic [15:0] cnt1;
  logic [15:0] cnt2;
  logic wrap1;
  logic wrap2;
  // Synchronised fault level
  logic fault_s;
  // Next-state values from the channel logic
  logic next_pin;
  logic next_armed;
  logic evt;

  // Fault pin is asynchronous, so it is synchronised first
  ocp_sync2 u_flt_sync (
    .mclk(mclk),
    .arst_n(arst_n),
    .d(fault_input_a),
    .q(fault_s)
  );

  // Two identical timebases
  ocp_timebase u_tb1 (
    .mclk(mclk),
    .arst_n(arst_n),
    .run(run_first),
    .period(first_period),
    .count(cnt1),
    .wrap(wrap1)
  );

  ocp_timebase u_tb2 (
    .mclk(mclk),
    .arst_n(arst_n),
    .run(run_second),
    .period(second_period),
    .count(cnt2),
    .wrap(wrap2)
  );

  // Write decode; commit once both address and data are held
  wire wr_go = aw_full && w_full && !s_axi_bvalid;
  wire hit_ctrl = wa == `OCP_OFF_CTRL;
  wire hit_pri = wa == `OCP_OFF_PRI;
  wire hit_sec = wa == `OCP_OFF_SEC;
  wire hit_prd1 = wa == `OCP_OFF_PRD1;
  wire hit_prd2 = wa == `OCP_OFF_PRD2;
  wire hit_trun = wa == `OCP_OFF_TRUN;
  wire hit_ists = wa == `OCP_OFF_ISTS;
  wire hit_imsk = wa == `OCP_OFF_IMSK;
  wire hit_cnt = wa == `OCP_OFF_CNT;
  wire wr_known = hit_ctrl | hit_pri | hit_sec | hit_prd1 | hit_prd2 | hit_trun | hit_ists
    | hit_imsk | hit_cnt;
  wire [15:0] wmask = {{8{ws[1]}}, {8{ws[0]}}};
  wire ctl_wr = wr_go && hit_ctrl;

  // Byte-lane merge of the held write data into a 16-bit register
  function automatic logic [15:0] merge(input logic [15:0] old);
    return (old & ~wmask) | (wd[15:0] & wmask);
  endfunction

  // Control register image; reserved bits read zero
  wire [15:0] ctrl_rd = {2'h0, idle_halt_select, 8'h00, pwm_fault_status, timebase_select,
    compare_mode_field};
  wire [15:0] ctrl_new = merge(ctrl_rd);
  wire [2:0] new_mode = ctrl_new[`OCP_MODE_HI:0];

  // Read decode on the offered address
  wire [7:0] ra = s_axi_araddr;
  wire rd_known = ra == `OCP_OFF_CTRL || ra == `OCP_OFF_PRI || ra == `OCP_OFF_SEC
    || ra == `OCP_OFF_PRD1 || ra == `OCP_OFF_PRD2 || ra == `OCP_OFF_TRUN
    || ra == `OCP_OFF_ISTS || ra == `OCP_OFF_IMSK || ra == `OCP_OFF_CNT;
  wire [31:0] rd_val =
    ra == `OCP_OFF_CTRL ? {16'h0000, ctrl_rd} :
    ra == `OCP_OFF_PRI ? {16'h0000, primary_compare_value} :
    ra == `OCP_OFF_SEC ? {16'h0000, secondary_compare_value} :
    ra == `OCP_OFF_PRD1 ? {16'h0000, first_period} :
    ra == `OCP_OFF_PRD2 ? {16'h0000, second_period} :
    ra == `OCP_OFF_TRUN ? {30'h00000000, run_second, run_first} :
    ra == `OCP_OFF_ISTS ? {30'h00000000, irq_status} :
    ra == `OCP_OFF_IMSK ? {30'h00000000, irq_mask} :
    ra == `OCP_OFF_CNT ? {cnt2, cnt1} : 32'h00000000;

  wire sel_run = timebase_select ? run_second : run_first;
  wire [15:0] sel_cnt = timebase_select ? cnt2 : cnt1;
  wire sel_wrap = timebase_select ? wrap2 : wrap1;
  wire halt = idle_halt_select && cpu_idle;
  // Channel acts only while the selected timer runs and no idle halt is in force
  wire act = sel_run && !halt;
  wire match_p = act && (sel_cnt == primary_compare_value);
  wire match_s = act && (sel_cnt == secondary_compare_value);
  wire is_pwmf = compare_mode_field == ocp_pkg::OCP_MODE_PWMF;
  wire is_pwm = is_pwmf || compare_mode_field == ocp_pkg::OCP_MODE_PWM;
  wire fault_ok = CHAN_ID <= `OCP_FAULT_CHANS;
  wire fault_live = fault_ok && is_pwmf && fault_s && !halt;
  // duty level for the present count
  wire pwm_level = sel_cnt < primary_compare_value;

  // Channel output behaviour per mode
  always_comb begin
    next_pin = compare_output_pin;
    next_armed = armed;
    evt = 1'b0;
    if (ctl_wr) begin
      next_pin = new_mode == ocp_pkg::OCP_MODE_CLR;
      next_armed = 1'b1;
    end else if (fault_live || (is_pwmf && pwm_fault_status)) begin
      next_pin = 1'b0;
    end else if (act) begin
      unique case (compare_mode_field)
        ocp_pkg::OCP_MODE_OFF: begin
          next_pin = 1'b0;
        end
        ocp_pkg::OCP_MODE_SET: begin
          if (match_p) begin
            next_pin = 1'b1;
            evt = 1'b1;
          end
        end
        ocp_pkg::OCP_MODE_CLR: begin
          if (match_p) begin
            next_pin = 1'b0;
            evt = 1'b1;
          end
        end
        ocp_pkg::OCP_MODE_TGL: begin
          if (match_p) begin
            next_pin = ~compare_output_pin;
            evt = 1'b1;
          end
        end
        ocp_pkg::OCP_MODE_ONE: begin
          if (match_s && compare_output_pin) begin
            next_pin = 1'b0;
            next_armed = 1'b0;
            evt = 1'b1;
          end else if (match_p && armed) begin
            next_pin = 1'b1;
          end
        end
        ocp_pkg::OCP_MODE_CONT: begin
          if (match_s && compare_output_pin) begin
            next_pin = 1'b0;
            evt = 1'b1;
          end else if (match_p) begin
            next_pin = 1'b1;
          end
        end
        default: begin
          next_pin = pwm_level;
        end
      endcase
    end
  end

  // Write address and data channels; each is taken independently
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      aw_full <= 1'b0;
      w_full <= 1'b0;
      wa <= 8'h00;
      wd <= 32'h00000000;
      ws <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        wa <= s_axi_awaddr;
        aw_full <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wd <= s_axi_wdata;
        ws <= s_axi_wstrb;
        w_full <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (wr_go) begin
        aw_full <= 1'b0;
        w_full <= 1'b0;
      end
      // Ready again only after the response is taken
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // Write response; unmapped offsets answer SLVERR
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `OCP_RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_known ? `OCP_RESP_OKAY : `OCP_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Read channel; data sampled at the address handshake
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `OCP_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_val;
      s_axi_rresp <= rd_known ? `OCP_RESP_OKAY : `OCP_RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // Software-written configuration
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      idle_halt_select <= 1'b0;
      timebase_select <= 1'b0;
      compare_mode_field <= ocp_pkg::OCP_MODE_OFF;
      secondary_compare_value <= `OCP_RST_REG;
      first_period <= `OCP_RST_REG;
      second_period <= `OCP_RST_REG;
      run_first <= 1'b0;
      run_second <= 1'b0;
      irq_mask <= `OCP_RST_IRQ;
    end else if (wr_go) begin
      if (hit_ctrl) begin
        idle_halt_select <= ctrl_new[`OCP_BIT_IDLE];
        timebase_select <= ctrl_new[`OCP_BIT_TSEL];
        compare_mode_field <= ocp_pkg::ocp_mode_t'(new_mode);
      end
      if (hit_sec) secondary_compare_value <= merge(secondary_compare_value);
      if (hit_prd1) first_period <= merge(first_period);
      if (hit_prd2) second_period <= merge(second_period);
      if (hit_trun && ws[0]) begin
        run_first <= wd[`OCP_BIT_RUN1];
        run_second <= wd[`OCP_BIT_RUN2];
      end
      if (hit_imsk && ws[0]) irq_mask <= wd[1:0];
    end
  end

  // Primary value; a read-only duty register in PWM modes
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      primary_compare_value <= `OCP_RST_REG;
    end else if (is_pwm && act && sel_wrap) begin
      primary_compare_value <= secondary_compare_value;
    end else if (wr_go && hit_pri && !is_pwm) begin
      primary_compare_value <= merge(primary_compare_value);
    end
  end

  // Pin, one-shot arm and fault status; fault set wins over mode rewrite
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      compare_output_pin <= 1'b0;
      armed <= 1'b0;
      pwm_fault_status <= 1'b0;
    end else begin
      compare_output_pin <= next_pin;
      armed <= next_armed;
      if (fault_live) pwm_fault_status <= 1'b1;
      else if (ctl_wr) pwm_fault_status <= 1'b0;
    end
  end

  // Sticky interrupt status, write one to clear, new event wins
  wire [1:0] sts_set = {fault_live && !pwm_fault_status, evt};
  wire [1:0] sts_clr = (wr_go && hit_ists && ws[0]) ? wd[1:0] : 2'h0;

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      irq_status <= `OCP_RST_IRQ;
      irq <= 1'b0;
    end else begin
      irq_status <= (irq_status & ~sts_clr) | sts_set;
      irq <= |(irq_status & irq_mask);
    end
  end

  default clocking @(posedge mclk); endclocking
  default disable iff (!arst_n);

  // Secondary match ending a pulse
  sequence s_pulse_end;
    !ctl_wr && act && match_s && compare_output_pin
      && compare_mode_field == ocp_pkg::OCP_MODE_ONE;
  endsequence

  idle_freeze_a: assert property (halt && !ctl_wr |=> $stable(compare_output_pin))
    else $error("pin moved while halted in idle");

  fault_sticky_a: assert property (pwm_fault_status && !ctl_wr |=> pwm_fault_status)
    else $error("fault status cleared without a mode rewrite");

  fault_stop_a: assert property (fault_live && !ctl_wr |=> pwm_fault_status
    && !compare_output_pin && irq_status[`OCP_IRQ_FLT])
    else $error("fault did not stop PWM output");

  fault_ignored_a: assert property (compare_mode_field == ocp_pkg::OCP_MODE_PWM
    && !pwm_fault_status |=> !pwm_fault_status)
    else $error("fault flagged in fault-disabled PWM");

  toggle_pin_a: assert property (!ctl_wr && !halt && compare_mode_field
    == ocp_pkg::OCP_MODE_TGL && match_p |=> compare_output_pin != $past(compare_output_pin))
    else $error("toggle mode did not invert the pin");

  force_high_a: assert property (!ctl_wr && compare_mode_field == ocp_pkg::OCP_MODE_SET
    && match_p |=> compare_output_pin ##1 compare_output_pin || $past(ctl_wr))
    else $error("pin not forced high on match");

  init_level_a: assert property (ctl_wr |=> compare_output_pin
    == (compare_mode_field == ocp_pkg::OCP_MODE_CLR))
    else $error("wrong initial pin level after mode write");

  single_pulse_a: assert property (s_pulse_end |=> !compare_output_pin
    && irq_status[`OCP_IRQ_EVT] && !armed)
    else $error("single pulse did not end with event flag");

  duty_load_a: assert property (is_pwm && act && sel_wrap && !ctl_wr
    |=> primary_compare_value == $past(secondary_compare_value))
    else $error("duty not reloaded at period match");

  duty_zero_a: assert property (is_pwm && !ctl_wr && act && !pwm_fault_status
    && primary_compare_value == 16'h0000 |=> !compare_output_pin)
    else $error("zero duty drove the pin high");

endmodule

`default_nettype wire

// ==== inc/ocp_cfg.svh ====
`ifndef OCP_CFG_SVH
`define OCP_CFG_SVH

// Register byte offsets on the AXI4-Lite slave
`define OCP_ADDR_W 8
`define OCP_OFF_CTRL 8'h00
`define OCP_OFF_PRI 8'h04
`define OCP_OFF_SEC 8'h08
`define OCP_OFF_PRD1 8'h0C
`define OCP_OFF_PRD2 8'h10
`define OCP_OFF_TRUN 8'h14
`define OCP_OFF_ISTS 8'h18
`define OCP_OFF_IMSK 8'h1C
`define OCP_OFF_CNT 8'h20

// Control register field positions
`define OCP_BIT_IDLE 13
`define OCP_BIT_FLT 4
`define OCP_BIT_TSEL 3
`define OCP_MODE_HI 2

// Timer run bits and interrupt status bits
`define OCP_BIT_RUN1 0
`define OCP_BIT_RUN2 1
`define OCP_IRQ_EVT 0
`define OCP_IRQ_FLT 1

// Reset values
`define OCP_RST_REG 16'h0000
`define OCP_RST_IRQ 2'h0

// Bus responses
`define OCP_RESP_OKAY 2'h0
`define OCP_RESP_SLVERR 2'h2

// Channels served by the shared fault pin
`define OCP_FAULT_CHANS 2

`endif

// ==== inc/ocp_pkg.sv ====
`default_nettype none

package ocp_pkg;

  // Compare mode field encodings
  typedef enum logic [2:0] {
    OCP_MODE_OFF = 3'h0,
    OCP_MODE_SET = 3'h1,
    OCP_MODE_CLR = 3'h2,
    OCP_MODE_TGL = 3'h3,
    OCP_MODE_ONE = 3'h4,
    OCP_MODE_CONT = 3'h5,
    OCP_MODE_PWM = 3'h6,
    OCP_MODE_PWMF = 3'h7
  } ocp_mode_t;

endpackage

`default_nettype wire

// ==== hw/ocp_sync2.sv ====
`timescale 1ns/1ps
`default_nettype none

// Two-stage synchroniser for a level from outside the clock domain
module ocp_sync2 (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic d,
  output var logic q
);

  // First stage; read only by the second stage
  logic meta;

  // Shift the pin level through two flops to settle metastability
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      meta <= 1'b0;
      q <= 1'b0;
    end else begin
      meta <= d;
      q <= meta;
    end
  end

endmodule

`default_nettype wire

// ==== hw/ocp_timebase.sv ====
`timescale 1ns/1ps
`default_nettype none

// 16-bit timebase counting mclk cycles up to its period value
module ocp_timebase (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic run,
  input wire logic [15:0] period,
  output var logic [15:0] count,
  output logic wrap
);

  // Period match while running; one cycle per period
  assign wrap = run && (count == period);

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      count <= 16'h0000;
    end else if (wrap) begin
      count <= 16'h0000;
    end else if (run) begin
      count <= count + 16'h0001;
    end
  end

  default clocking @(posedge mclk); endclocking
  default disable iff (!arst_n);

  timer_wrap_a: assert property (wrap |=> count == 16'h0000)
    else $error("timebase did not restart from zero on period match");

  timer_step_a: assert property (run && !wrap |=> count == $past(count) + 16'h0001)
    else $error("timebase did not advance by one count");

endmodule

`default_nettype wire

// ==== verif/ocp_fault_src.sv ====
`timescale 1ns/1ps
`default_nettype none

// Far-side fault source, plus a load on the compare output
module ocp_fault_src (
  input wire logic mclk,
  input wire logic trip,
  input wire logic compare_output_pin,
  output var logic fault_input_a
);
  // Level the load last saw on the pin, for debug only
  logic load_level;

  // The fault line is asynchronous, so it moves well away from the edge
  // shared fault pin
  always @(posedge mclk) begin
    fault_input_a <= #7 trip;
    load_level <= compare_output_pin;
  end

  // Quiet line at time zero
  initial begin
    fault_input_a = 1'b0;
  end
endmodule

`default_nettype wire

// ==== verif/tb_output_compare_pwm_channel.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "ocp_cfg.svh"

// Register-level bench for one compare channel
module tb_output_compare_pwm_channel;
  logic mclk = 1'b0;
  logic arst_n = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0, rdata;
  logic awready, wready, bvalid, arready, rvalid, pin, irq, fault, trip = 1'b0;
  logic cpu_idle = 1'b0;
  logic [1:0] bresp, rresp;
  int mismatches = 0;
  int cmp_count = 0;
  logic [31:0] rd_v;
  logic [1:0] rsp;
  int h;

  // 40 MHz clock
  always #12.5 mclk = ~mclk;

  ocp_top dut (.mclk(mclk), .arst_n(arst_n), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .cpu_idle(cpu_idle), .fault_input_a(fault), .compare_output_pin(pin), .irq(irq));

  ocp_fault_src far (.mclk(mclk), .trip(trip), .compare_output_pin(pin), .fault_input_a(fault));

  // Compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Write: address and data offered together, each released when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge mclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever begin
      @(posedge mclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) begin
        r = bresp;
        bready <= 1'b0;
        break;
      end
    end
  endtask

  // Write that must be accepted
  task automatic wok(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    wr(a, d, r);
    chk(r, `OCP_RESP_OKAY);
  endtask

  // Read: answer carried by the edge where rvalid is seen
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge mclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(posedge mclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        break;
      end
    end
  endtask

  // Wait a bounded time for a pin level, then check it
  task automatic wait_pin(input logic l);
    for (int n = 0; n < 60 && pin !== l; n++) @(posedge mclk);
    chk(pin, l);
  endtask

  // Pin must keep one level for 30 cycles
  task automatic hold(input logic l);
    int b;
    b = 0;
    repeat (30) begin
      @(posedge mclk);
      if (pin !== l) b++;
    end
    chk(b, 0);
  endtask

  // High cycles over one ten-count period
  task automatic high_cnt(output int c);
    c = 0;
    repeat (10) begin
      @(posedge mclk);
      if (pin === 1'b1) c++;
    end
  endtask

  // New secondary value, settle two periods, then measure
  task automatic duty(input logic [15:0] s, input int e);
    wok(`OCP_OFF_SEC, {16'h0, s});
    repeat (25) @(posedge mclk);
    high_cnt(h);
    chk(h, e);
  endtask

  // Single place where the run ends
  task automatic report_and_stop();
    if (mismatches == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // Watchdog against a hung handshake
  initial begin
    repeat (20000) @(posedge mclk);
    mismatches++;
    report_and_stop();
  end

  initial begin
    repeat (3) @(posedge mclk);
    arst_n <= 1'b1;
    // Reset values, and an unmapped place refused
    rd(`OCP_OFF_CTRL, rd_v, rsp);
    chk(rd_v, 32'h0);
    rd(8'h40, rd_v, rsp);
    chk(rd_v, 32'h0);
    chk(rsp, `OCP_RESP_SLVERR);
    wr(8'h44, 32'h1, rsp);
    chk(rsp, `OCP_RESP_SLVERR);
    chk({pin, irq}, 2'h0);
    wok(`OCP_OFF_PRI, 32'h5);
    wok(`OCP_OFF_SEC, 32'h8);
    wok(`OCP_OFF_PRD1, 32'h14);
    wok(`OCP_OFF_TRUN, 32'h1);
    hold(1'b0);
    // toggle returns to the start level; start levels
    for (int m = 1; m < 4; m++) begin
      wok(`OCP_OFF_CTRL, m);
      // Seen at the response edge, before any match can move the pin
      chk(pin, m == 2);
      wait_pin(m != 2);
      if (m == 3) wait_pin(1'b0);
    end
    // one pulse, then low for good, event flag set
    wok(`OCP_OFF_CTRL, {29'h0, ocp_pkg::OCP_MODE_ONE});
    // Drop events left by the earlier modes so only the pulse can set the flag
    wok(`OCP_OFF_ISTS, 32'h1);
    wait_pin(1'b1);
    wait_pin(1'b0);
    hold(1'b0);
    rd(`OCP_OFF_ISTS, rd_v, rsp);
    chk(rd_v[`OCP_IRQ_EVT], 1'b1);
    // Masked flag keeps irq low; unmasked raises it; W1C drops it
    chk(irq, 1'b0);
    wok(`OCP_OFF_IMSK, 32'h1);
    @(posedge mclk);
    chk(irq, 1'b1);
    wok(`OCP_OFF_ISTS, 32'h1);
    @(posedge mclk);
    chk(irq, 1'b0);
    // pulses repeat with no further writes
    wok(`OCP_OFF_CTRL, {29'h0, ocp_pkg::OCP_MODE_CONT});
    wait_pin(1'b1);
    wait_pin(1'b0);
    wait_pin(1'b1);
    // second timebase selected while stopped gives no match
    wok(`OCP_OFF_PRD2, 32'h14);
    wok(`OCP_OFF_CTRL, 32'h9);
    hold(1'b0);
    wok(`OCP_OFF_TRUN, 32'h3);
    wait_pin(1'b1);
    // idle freezes the toggle only when the halt bit is set
    // Idle goes up first, so no match slips in before the freeze
    cpu_idle <= 1'b1;
    wok(`OCP_OFF_CTRL, 32'h2003);
    hold(1'b0);
    wok(`OCP_OFF_CTRL, 32'h0003);
    wait_pin(1'b1);
    cpu_idle <= 1'b0;
    // PWM with a ten-count period; primary writes ignored in PWM
    wok(`OCP_OFF_TRUN, 32'h1);
    // Shrink the period only while the count is low, else the timer runs to the top
    rd_v = 32'h0000FFFF;
    while (rd_v[15:0] > 16'h0003) rd(`OCP_OFF_CNT, rd_v, rsp);
    wok(`OCP_OFF_PRD1, 32'h9);
    wok(`OCP_OFF_CTRL, {29'h0, ocp_pkg::OCP_MODE_PWM});
    duty(16'h0004, 4);
    wok(`OCP_OFF_PRI, 32'h8);
    duty(16'h0004, 4);
    duty(16'h0000, 0);
    duty(16'h000A, 10);
    duty(16'h0009, 9);
    duty(16'h0004, 4);
    trip <= 1'b1;
    repeat (10) @(posedge mclk);
    high_cnt(h);
    chk(h, 4);
    trip <= 1'b0;
    repeat (5) @(posedge mclk);
    // fault forces the pin low and latches status
    wok(`OCP_OFF_CTRL, {29'h0, ocp_pkg::OCP_MODE_PWMF});
    repeat (25) @(posedge mclk);
    high_cnt(h);
    chk(h, 4);
    trip <= 1'b1;
    repeat (12) @(posedge mclk);
    trip <= 1'b0;
    hold(1'b0);
    rd(`OCP_OFF_CTRL, rd_v, rsp);
    chk(rd_v, 32'h17);
    rd(`OCP_OFF_ISTS, rd_v, rsp);
    chk(rd_v[`OCP_IRQ_FLT], 1'b1);
    // Rewriting the mode ends the fault hold
    wok(`OCP_OFF_CTRL, {29'h0, ocp_pkg::OCP_MODE_PWMF});
    repeat (25) @(posedge mclk);
    high_cnt(h);
    chk(h, 4);
    report_and_stop();
  end
endmodule

`default_nettype wire
